// File: core/aux_scan_pkg.sv
/*
  Constants, register map and field layout for the auxiliary input scan sequencer.
  Assumes a 100 MHz hclk and a 32-bit AHB-Lite register bus with word-aligned registers.
*/
// Behaviour
// - Only channels with enable bit set convert
// - Writing one to scan bit starts scan
// - Aux starts after power-up, cells, diagnostic
// - Channel one first, then two; skip disabled
// - Each result goes to its own register
// - Bias switch closes on scan request; stays open with no channel enabled
// - Settling delay field, step equals minimum
// - Settling delay before every enabled channel
// - Charge pump off for whole scan
// - Results are 12-bit codes of bias supply
// - Conversion within 10 or 17 us
// - Stored result compared with both thresholds
// - Enabled violation sets hot or cold alert
// - Hot and cold enables held per channel
// - Alerts clear when later conversion passes
// - Alarm enables forward alerts to alarm pin
package aux_scan_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_ALERT_STATUS = 8'h02;
  localparam logic [7:0] IDX_CONVERTER_CONFIG = 8'h08;
  localparam logic [7:0] IDX_ACQUISITION_CONFIG = 8'h0c;
  localparam logic [7:0] IDX_SCAN_CONTROL = 8'h10;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h11;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h12;
  localparam logic [7:0] IDX_COLD_THRESHOLD = 8'h1e;
  localparam logic [7:0] IDX_HOT_THRESHOLD = 8'h1f;
  localparam logic [7:0] IDX_AUX_ONE_RESULT = 8'h40;
  localparam logic [7:0] IDX_AUX_TWO_RESULT = 8'h41;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG_AUX_ONE_EN = 0;
  localparam int CFG_AUX_TWO_EN = 1;
  localparam int CFG_HOT_ALARM_EN = 2;
  localparam int CFG_COLD_ALARM_EN = 3;
  localparam int ST_COLD_ALERT = 0;
  localparam int ST_HOT_ALERT = 1;
  localparam int ST_BUSY = 15;
  localparam int RES_HOT_EN = 0;
  localparam int RES_COLD_EN = 1;
  localparam int RES_CODE_LSB = 4;
  localparam int SCAN_BIT = 0;
  localparam int IRQ_SCAN_DONE = 0;
  localparam int IRQ_HOT = 1;
  localparam int IRQ_COLD = 2;
  localparam int IRQ_OVERRUN = 3;
  localparam int IRQ_W = 4;
  localparam int SETTLE_W = 6;
  localparam int CODE_W = 12;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_CONVERTER_CONFIG = 16'h0000;
  localparam logic [15:0] RST_ACQUISITION_CONFIG = 16'h0000;
  localparam logic [15:0] RST_THRESHOLD_COLD = 16'hfff0;
  localparam logic [15:0] RST_THRESHOLD_HOT = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SETTLE_STEP_PS = 5300000;
  localparam int CONV_ONE_PS = 10000000;
  localparam int CONV_TWO_PS = 17000000;
  localparam int SETTLE_STEP_CYC = (SETTLE_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_ONE_CYC = CONV_ONE_PS / CLK_PERIOD_PS;
  localparam int CONV_TWO_CYC = CONV_TWO_PS / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    S_IDLE, S_PRE, S_SETTLE, S_CONVERT, S_NEXT
  } scan_state_t;

endpackage

// File: core/aux_input_scan_sequencer.sv
/*
  Auxiliary input scan sequencer: AHB-Lite register slave, scan state machine,
  settling timer, result store, threshold alerts, alarm and interrupt.
  Assumes an external converter with a start/done handshake, a power-up
  indication and a level marking that cell and diagnostic conversions are done.
*/
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module aux_input_scan_sequencer import aux_scan_pkg::*; #(
  parameter bit HOT_WHEN_ABOVE = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic powerup_done,
  input wire logic cells_diag_done,
  input wire logic adc_done,
  input wire logic [CODE_W-1:0] adc_result,
  output logic adc_start,
  output logic adc_channel,
  output logic scan_request,
  output logic thermistor_bias_supply,
  output logic charge_pump_enable,
  output logic alarm_output_pin,
  output logic irq
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [15:0] converter_config_ff;
  logic [15:0] acquisition_config_ff;
  logic [15:0] cold_threshold_ff;
  logic [15:0] hot_threshold_ff;
  logic [CODE_W-1:0] code_ff [2];
  logic [1:0] hot_en_ff [2];
  logic [1:0] hot_viol_ff;
  logic [1:0] cold_viol_ff;
  logic [IRQ_W-1:0] irq_status_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [31:0] hrdata_ff;

  // ------------------------------------------------------------
  // Bus phase capture
  // ------------------------------------------------------------
  logic wr_pend_ff;
  logic [7:0] wr_idx_ff;
  logic addr_ok;
  logic rd_take;
  logic [7:0] a_idx;
  logic [15:0] wdat;
  logic wr_now;

  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_now && (wr_idx_ff == idx);
  endfunction

  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign a_idx = haddr[9:2];
  assign addr_ok = ce && hsel && hready && htrans[1];
  assign rd_take = addr_ok && !hwrite;
  assign wr_now = ce && wr_pend_ff;
  assign wdat = hwdata[15:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
    end else if (ce) begin
      wr_pend_ff <= addr_ok && hwrite;
      if (addr_ok && hwrite) begin
        wr_idx_ff <= a_idx;
      end
    end
  end

  // ------------------------------------------------------------
  // Scan sequencing
  // ------------------------------------------------------------
  scan_state_t state_ff;
  logic ch_ff;
  logic [15:0] settle_cnt_ff;
  logic [10:0] conv_cnt_ff;
  logic overrun_ff;
  logic busy;
  logic start_scan;
  logic ch_one_en;
  logic ch_two_en;
  logic first_ch;
  logic has_second;
  logic [15:0] settle_total;
  logic [10:0] conv_limit;
  logic store;

  assign busy = (state_ff != S_IDLE);
  assign ch_one_en = converter_config_ff[CFG_AUX_ONE_EN];
  assign ch_two_en = converter_config_ff[CFG_AUX_TWO_EN];
  assign start_scan = wr_hit(IDX_SCAN_CONTROL) && wdat[SCAN_BIT] && !busy;
  // Channel one leads when enabled, otherwise channel two
  assign first_ch = !ch_one_en;
  assign has_second = (ch_ff == 1'b0) && ch_two_en;
  // Setting n means n+1 steps; 64 steps at most
  assign settle_total = 16'((acquisition_config_ff[SETTLE_W-1:0] + 7'd1)
                        * SETTLE_STEP_CYC);
  assign conv_limit = (ch_one_en && ch_two_en) ? 11'(CONV_TWO_CYC)
                                               : 11'(CONV_ONE_CYC);
  assign store = (state_ff == S_CONVERT) && adc_done && ce;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= S_IDLE;
      ch_ff <= 1'b0;
    end else if (ce) begin
      unique case (state_ff)
        S_IDLE: begin
          if (start_scan) begin
            state_ff <= S_PRE;
          end
        end
        S_PRE: begin
          if (powerup_done && cells_diag_done) begin
            ch_ff <= first_ch;
            state_ff <= (ch_one_en || ch_two_en) ? S_SETTLE : S_NEXT;
          end
        end
        S_SETTLE: begin
          if (settle_cnt_ff == 16'h0001) begin
            state_ff <= S_CONVERT;
          end
        end
        S_CONVERT: begin
          if (adc_done) begin
            if (has_second) begin
              ch_ff <= 1'b1;
              state_ff <= S_SETTLE;
            end else begin
              state_ff <= S_NEXT;
            end
          end
        end
        S_NEXT: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // Loaded on entry to each settling phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt_ff <= 16'h0000;
    end else if (ce) begin
      if ((state_ff == S_PRE) || (state_ff == S_CONVERT)) begin
        settle_cnt_ff <= settle_total;
      end else if (state_ff == S_SETTLE) begin
        settle_cnt_ff <= settle_cnt_ff - 16'h0001;
      end
    end
  end

  // Conversion budget counts only converter time, not settling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_cnt_ff <= 11'h000;
      overrun_ff <= 1'b0;
    end else if (ce) begin
      overrun_ff <= 1'b0;
      if (start_scan) begin
        conv_cnt_ff <= 11'h000;
      end else if (state_ff == S_CONVERT) begin
        if (conv_cnt_ff == conv_limit) begin
          overrun_ff <= 1'b1;
        end
        if (conv_cnt_ff != 11'h7ff) begin
          conv_cnt_ff <= conv_cnt_ff + 11'h001;
        end
      end
    end
  end

  // Converter request is a one-cycle pulse on entry to conversion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_start <= 1'b0;
      adc_channel <= 1'b0;
      scan_request <= 1'b0;
    end else if (ce) begin
      adc_start <= (state_ff == S_SETTLE) && (settle_cnt_ff == 16'h0001);
      adc_channel <= ch_ff;
      scan_request <= start_scan;
    end
  end

  // ------------------------------------------------------------
  // Supplies
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thermistor_bias_supply <= 1'b0;
      charge_pump_enable <= 1'b1;
    end else if (ce) begin
      if (start_scan) begin
        thermistor_bias_supply <= ch_one_en || ch_two_en;
        charge_pump_enable <= 1'b0;
      end else if (state_ff == S_NEXT) begin
        thermistor_bias_supply <= 1'b0;
        charge_pump_enable <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Results, thresholds and alerts
  // ------------------------------------------------------------
  logic [CODE_W-1:0] hot_thr;
  logic [CODE_W-1:0] cold_thr;
  logic over_hot;
  logic under_cold;

  assign hot_thr = hot_threshold_ff[RES_CODE_LSB +: CODE_W];
  assign cold_thr = cold_threshold_ff[RES_CODE_LSB +: CODE_W];
  // Polarity depends on the sensor network, so it is a build choice
  assign over_hot = HOT_WHEN_ABOVE ? (adc_result > hot_thr)
                                   : (adc_result < hot_thr);
  assign under_cold = HOT_WHEN_ABOVE ? (adc_result < cold_thr)
                                     : (adc_result > cold_thr);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          code_ff[g] <= '0;
          hot_en_ff[g] <= 2'b00;
          hot_viol_ff[g] <= 1'b0;
          cold_viol_ff[g] <= 1'b0;
        end else if (ce) begin
          if (wr_hit(IDX_AUX_ONE_RESULT + 8'(g))) begin
            hot_en_ff[g] <= {wdat[RES_COLD_EN], wdat[RES_HOT_EN]};
          end
          if (store && (ch_ff == 1'(g))) begin
            code_ff[g] <= adc_result;
            // Recomputed on every store, so a passing result clears it
            hot_viol_ff[g] <= hot_en_ff[g][RES_HOT_EN] && over_hot;
            cold_viol_ff[g] <= hot_en_ff[g][RES_COLD_EN] && under_cold;
          end
        end
      end
    end
  endgenerate

  logic hot_alert_flag;
  logic cold_alert_flag;
  logic hot_alert_d_ff;
  logic cold_alert_d_ff;

  assign hot_alert_flag = |hot_viol_ff;
  assign cold_alert_flag = |cold_viol_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_output_pin <= 1'b0;
      hot_alert_d_ff <= 1'b0;
      cold_alert_d_ff <= 1'b0;
    end else if (ce) begin
      alarm_output_pin <= (hot_alert_flag && converter_config_ff[CFG_HOT_ALARM_EN])
                       || (cold_alert_flag && converter_config_ff[CFG_COLD_ALARM_EN]);
      hot_alert_d_ff <= hot_alert_flag;
      cold_alert_d_ff <= cold_alert_flag;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_config_ff <= RST_CONVERTER_CONFIG;
      acquisition_config_ff <= RST_ACQUISITION_CONFIG;
      cold_threshold_ff <= RST_THRESHOLD_COLD;
      hot_threshold_ff <= RST_THRESHOLD_HOT;
      irq_mask_ff <= RST_IRQ_MASK;
    end else if (ce) begin
      if (wr_hit(IDX_CONVERTER_CONFIG)) begin
        converter_config_ff <= wdat;
      end
      if (wr_hit(IDX_ACQUISITION_CONFIG)) begin
        acquisition_config_ff <= wdat;
      end
      if (wr_hit(IDX_COLD_THRESHOLD)) begin
        cold_threshold_ff <= wdat;
      end
      if (wr_hit(IDX_HOT_THRESHOLD)) begin
        hot_threshold_ff <= wdat;
      end
      if (wr_hit(IDX_IRQ_MASK)) begin
        irq_mask_ff <= wdat[IRQ_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt status: read clears, a same-cycle event wins
  // ------------------------------------------------------------
  logic [IRQ_W-1:0] irq_events;
  logic irq_rd;

  assign irq_events[IRQ_SCAN_DONE] = (state_ff == S_NEXT) && ce;
  assign irq_events[IRQ_HOT] = hot_alert_flag && !hot_alert_d_ff && ce;
  assign irq_events[IRQ_COLD] = cold_alert_flag && !cold_alert_d_ff && ce;
  assign irq_events[IRQ_OVERRUN] = overrun_ff && ce;
  assign irq_rd = rd_take && (a_idx == IDX_IRQ_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_ff <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_status_ff <= (irq_rd ? '0 : irq_status_ff) | irq_events;
      irq <= |(((irq_rd ? '0 : irq_status_ff) | irq_events) & irq_mask_ff);
    end
  end

  // ------------------------------------------------------------
  // Read data, captured in the address phase
  // ------------------------------------------------------------
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    unique case (a_idx)
      IDX_ALERT_STATUS: begin
        rd_mux[ST_HOT_ALERT] = hot_alert_flag;
        rd_mux[ST_COLD_ALERT] = cold_alert_flag;
        rd_mux[ST_BUSY] = busy;
      end
      IDX_CONVERTER_CONFIG: rd_mux = converter_config_ff;
      IDX_ACQUISITION_CONFIG: rd_mux = acquisition_config_ff;
      IDX_SCAN_CONTROL: rd_mux[SCAN_BIT] = busy;
      IDX_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_ff;
      IDX_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_ff;
      IDX_COLD_THRESHOLD: rd_mux = cold_threshold_ff;
      IDX_HOT_THRESHOLD: rd_mux = hot_threshold_ff;
      IDX_AUX_ONE_RESULT: rd_mux = {code_ff[0], 2'b00, hot_en_ff[0][1], hot_en_ff[0][0]};
      IDX_AUX_TWO_RESULT: rd_mux = {code_ff[1], 2'b00, hot_en_ff[1][1], hot_en_ff[1][0]};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_ff <= {16'h0000, rd_mux};
    end
  end

endmodule

// File: bench/aux_converter_model.sv
/*
  Converter and thermistor network model for the aux scan sequencer.
  Assumes codes and latency come from the bench.
*/
`timescale 1ns/100ps
module aux_converter_model import aux_scan_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scan_request,
  input wire logic thermistor_bias_supply,
  input wire logic adc_start,
  input wire logic adc_channel,
  input wire logic [CODE_W-1:0] code_one,
  input wire logic [CODE_W-1:0] code_two,
  input wire logic [7:0] lat,
  output logic powerup_done,
  output logic cells_diag_done,
  output logic adc_done,
  output logic [CODE_W-1:0] adc_result
);
  logic [7:0] cnt_ff;
  logic [3:0] diag_ff;
  logic busy_ff;
  logic ch_ff;
  logic diag_ok_ff;
  logic [CODE_W-1:0] code;
  // ----
  // Cell and diagnostic phase
  // ----
  // A new scan never sees the last scan's done level
  assign cells_diag_done = diag_ok_ff & ~scan_request;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      powerup_done <= 1'b0;
      diag_ok_ff <= 1'b0;
      diag_ff <= 4'hf;
    end else begin
      powerup_done <= 1'b1;
      diag_ok_ff <= ~scan_request & (diag_ff == 4'h0);
      diag_ff <= scan_request ? 4'hf : diag_ff - {3'h0, diag_ff != 4'h0};
    end
  end
  // ----
  // Conversion
  // ----
  // Open bias switch leaves the divider unpowered
  assign code = !thermistor_bias_supply ? 12'h000 : (ch_ff ? code_two : code_one);
  // Outside the done pulse the bus shows the inverse, never a stale code
  assign adc_result = adc_done ? code : ~code;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      ch_ff <= 1'b0;
      adc_done <= 1'b0;
    end else begin
      adc_done <= busy_ff && (cnt_ff == 8'h00);
      if (adc_start) begin
        busy_ff <= 1'b1;
        cnt_ff <= lat;
        ch_ff <= adc_channel;
      end else if (busy_ff) begin
        busy_ff <= (cnt_ff != 8'h00);
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule

// File: bench/aux_scan_checker.sv
/*
  Port assertions for the aux scan sequencer.
  Assumes it is bound onto aux_input_scan_sequencer.
*/
`timescale 1ns/100ps
module aux_scan_checker import aux_scan_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic powerup_done,
  input wire logic cells_diag_done,
  input wire logic adc_done,
  input wire logic adc_start,
  input wire logic adc_channel,
  input wire logic scan_request,
  input wire logic thermistor_bias_supply,
  input wire logic charge_pump_enable,
  input wire logic alarm_output_pin,
  input wire logic irq
);
  logic [15:0] gap_ff;
  logic two_seen_ff;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----
  // Helpers
  // ----
  // Saturates so an idle block never wraps into a false failure
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_ff <= 16'h0000;
    end else if (scan_request || adc_done) begin
      gap_ff <= 16'h0000;
    end else if (gap_ff != 16'hffff) begin
      gap_ff <= gap_ff + 16'h0001;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      two_seen_ff <= 1'b0;
    end else begin
      two_seen_ff <= !scan_request && (two_seen_ff || (adc_start && adc_channel));
    end
  end
  // ----
  // Assertions
  // ----
  AST_START_PULSE: assert property (adc_start |=> !adc_start)
    else $error("adc_start longer than one cycle");
  AST_SCAN_PULSE: assert property (scan_request |=> !scan_request)
    else $error("scan_request longer than one cycle");
  AST_PUMP_OFF: assert property (scan_request |-> !charge_pump_enable)
    else $error("pump on at scan request");
  AST_BIAS_CONV: assert property (adc_start |->
    thermistor_bias_supply && !charge_pump_enable)
    else $error("conversion without bias or with pump on");
  AST_AFTER_CELLS: assert property (adc_start |-> powerup_done && cells_diag_done)
    else $error("aux conversion before cells done");
  AST_SETTLE: assert property (adc_start |-> gap_ff >= 16'(SETTLE_STEP_CYC))
    else $error("settling delay too short");
  AST_ORDER: assert property (adc_start |-> !two_seen_ff)
    else $error("conversion after channel two");
  AST_END: assert property ($fell(thermistor_bias_supply) |-> charge_pump_enable)
    else $error("bias opened with pump off");
  AST_PUMP_BACK: assert property (adc_done && adc_channel |-> ##[1:8] charge_pump_enable)
    else $error("pump not back after last store");
  COV_TWO: cover property (adc_start && adc_channel);
  COV_ALARM: cover property ($rose(alarm_output_pin));
  COV_IRQ: cover property ($rose(irq));
endmodule

bind aux_input_scan_sequencer aux_scan_checker i_aux_scan_checker (.hclk(hclk),
  .hresetn(hresetn), .powerup_done(powerup_done), .cells_diag_done(cells_diag_done),
  .adc_done(adc_done), .adc_start(adc_start), .adc_channel(adc_channel),
  .scan_request(scan_request), .thermistor_bias_supply(thermistor_bias_supply),
  .charge_pump_enable(charge_pump_enable), .alarm_output_pin(alarm_output_pin), .irq(irq));

// File: bench/tb_top.sv
/*
  Testbench: AHB-Lite register traffic and scan checks.
  Assumes the converter model and the bound checker.
*/
`timescale 1ns/100ps
module tb_top import aux_scan_pkg::*; ;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b1;
  logic [2:0] hsize = 3'h2;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, powerup_done, cells_diag_done, adc_done, adc_start, adc_channel;
  logic scan_request, thermistor_bias_supply, charge_pump_enable, alarm_output_pin, irq;
  logic [CODE_W-1:0] adc_result, code_one = 12'h000, code_two = 12'h000;
  logic [7:0] lat = 8'h05;
  logic bias_at_req = 1'b0, bias_seen = 1'b0;
  int errors = 0, n_compared = 0, cyc = 0, done_t = 0, gap = 0, st0 = 0, st1 = 0;
  logic [7:0] ridx [5] = '{IDX_CONVERTER_CONFIG, IDX_ACQUISITION_CONFIG,
    IDX_COLD_THRESHOLD, IDX_HOT_THRESHOLD, IDX_IRQ_MASK};
  logic [15:0] rval [5] = '{RST_CONVERTER_CONFIG, RST_ACQUISITION_CONFIG,
    RST_THRESHOLD_COLD, RST_THRESHOLD_HOT, 16'(RST_IRQ_MASK)};
  initial begin
    forever #5 hclk = ~hclk;
  end
  aux_input_scan_sequencer i_aux_input_scan_sequencer (.hclk(hclk), .hresetn(hresetn),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .powerup_done(powerup_done), .cells_diag_done(cells_diag_done),
    .adc_done(adc_done), .adc_result(adc_result), .adc_start(adc_start),
    .adc_channel(adc_channel), .scan_request(scan_request),
    .thermistor_bias_supply(thermistor_bias_supply), .charge_pump_enable(charge_pump_enable),
    .alarm_output_pin(alarm_output_pin), .irq(irq));
  aux_converter_model i_aux_converter_model (.hclk(hclk), .hresetn(hresetn),
    .scan_request(scan_request), .thermistor_bias_supply(thermistor_bias_supply),
    .adc_start(adc_start), .adc_channel(adc_channel), .code_one(code_one),
    .code_two(code_two), .lat(lat), .powerup_done(powerup_done),
    .cells_diag_done(cells_diag_done), .adc_done(adc_done), .adc_result(adc_result));
  // ----
  // Monitor, sees values from before each edge
  // ----
  always @(posedge hclk) begin
    cyc++;
    st0 += (adc_start === 1'b1 && adc_channel === 1'b0);
    st1 += (adc_start === 1'b1 && adc_channel === 1'b1);
    if (adc_done === 1'b1) done_t = cyc;
    if (adc_start === 1'b1 && adc_channel === 1'b1) gap = cyc - done_t;
    if (scan_request === 1'b1) bias_at_req = thermistor_bias_supply;
    bias_seen |= (thermistor_bias_supply === 1'b1);
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input bit wr, input logic [7:0] idx, input logic [15:0] wd);
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 16'h0000);
    chk(rd, exp);
  endtask
  // Order: bias, pump, alarm, irq
  task automatic pins(input logic [3:0] exp);
    #1;
    chk({28'h0, thermistor_bias_supply, charge_pump_enable, alarm_output_pin, irq}, {28'h0, exp});
    @(posedge hclk);
  endtask
  task automatic scan(input logic [15:0] cfg);
    int i;
    bus(1'b1, IDX_CONVERTER_CONFIG, cfg);
    st0 = 0;
    st1 = 0;
    bias_seen = 1'b0;
    bus(1'b1, IDX_SCAN_CONTROL, 16'h0001);
    rdchk(IDX_SCAN_CONTROL, 32'h1);
    i = 0;
    do begin
      @(posedge hclk);
      #1;
      i++;
    end while (charge_pump_enable !== 1'b1 && i < 5000);
    if (i >= 5000) errors++;
    repeat (4) @(posedge hclk);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #500000;
    errors++;
    test_done();
  end
  // ----
  // Tests
  // ----
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int k = 0; k < 5; k++) rdchk(ridx[k], {16'h0, rval[k]});
    bus(1'b1, 8'h20, 16'hffff);
    rdchk(8'h20, 32'h0);
    bus(1'b1, IDX_ACQUISITION_CONFIG, 16'h00ff);
    rdchk(IDX_ACQUISITION_CONFIG, 32'hff);
    bus(1'b1, IDX_ACQUISITION_CONFIG, 16'h0000);
    bus(1'b1, IDX_IRQ_MASK, 16'h000f);
    $display("test registers done");
    bus(1'b1, IDX_HOT_THRESHOLD, 16'h8000);
    bus(1'b1, IDX_AUX_TWO_RESULT, 16'h0001);
    code_two <= 12'h900;
    scan(16'h0006);
    chk({st0[15:0], st1[15:0]}, 32'h0000_0001);
    chk(32'(bias_at_req), 32'h1);
    rdchk(IDX_AUX_TWO_RESULT, 32'h9001);
    rdchk(IDX_ALERT_STATUS, 32'h2);
    pins(4'b0111);
    rdchk(IDX_IRQ_STATUS, 32'h3);
    pins(4'b0110);
    $display("test one channel done");
    bus(1'b1, IDX_ACQUISITION_CONFIG, 16'h0001);
    bus(1'b1, IDX_COLD_THRESHOLD, 16'h1000);
    bus(1'b1, IDX_AUX_ONE_RESULT, 16'h0002);
    code_one <= 12'h050;
    code_two <= 12'h700;
    lat <= 8'hc8;
    scan(16'h0007);
    chk({st0[15:0], st1[15:0]}, 32'h0001_0001);
    chk(32'(gap >= 2 * SETTLE_STEP_CYC && gap <= 2 * SETTLE_STEP_CYC + 6), 32'h1);
    rdchk(IDX_AUX_ONE_RESULT, 32'h0502);
    rdchk(IDX_AUX_TWO_RESULT, 32'h7001);
    rdchk(IDX_ALERT_STATUS, 32'h1);
    pins(4'b0101);
    rdchk(IDX_IRQ_STATUS, 32'h5);
    $display("test two channels done");
    bus(1'b1, IDX_IRQ_MASK, 16'h0000);
    scan(16'h0000);
    chk({st0[15:0], st1[15:0]}, 32'h0);
    chk(32'(bias_seen), 32'h0);
    pins(4'b0100);
    rdchk(IDX_IRQ_STATUS, 32'h1);
    $display("test no channel done");
    test_done();
  end
endmodule
